// file: logic/asfr_defines.svh
`ifndef ASFR_DEFINES_SVH
`define ASFR_DEFINES_SVH

// =====================================================
// register map
`define ASFR_STATUS_OFS      12'h000
`define ASFR_EXEC_OFS        12'h004
`define ASFR_STATUS_RESET    16'h0000

// =====================================================
// status word fields
`define ASFR_HALF_CARRY_BIT  8
`define ASFR_PRIO_HI         7
`define ASFR_PRIO_LO         5
`define ASFR_LOOP_BIT        4
`define ASFR_NEG_BIT         3
`define ASFR_WRAP_BIT        2
`define ASFR_ZERO_BIT        1
`define ASFR_CARRY_BIT       0
`define ASFR_IMPL_MASK       16'h01ff
`define ASFR_PRIO_BLOCK      3'h7
`define ASFR_EXT_LEVEL_BASE  4'h8

`endif

// file: logic/asfr_pkg.sv
package asfr_pkg;
  // flag update from the execution logic
  typedef struct packed {
    logic        valid;
    logic        word_op;
    logic [15:0] result;
    logic        carry_out;
    logic        half_carry_b4;
    logic        half_carry_b8;
    logic        signed_ovf;
    logic [4:0]  affect;
  } asfr_upd_type;

  typedef enum logic [1:0] {
    ASFR_APB_IDLE,
    ASFR_APB_SETUP,
    ASFR_APB_ACCESS
  } asfr_apb_state_type;
endpackage

// file: logic/asfr_flag_calc.sv
`timescale 1ns/1ps
`include "asfr_defines.svh"

module asfr_flag_calc
  import asfr_pkg::*;
(
  // update request
  input  wire asfr_upd_type upd,
  input  wire logic [4:0]   cur_flags,
  // computed flags: hc, n, ov, z, c
  output logic [4:0]        nxt_flags
);
  logic neg;
  logic nonzero;
  logic hc;

  always_comb begin
    neg       = upd.word_op ? upd.result[15] : upd.result[7];
    nonzero   = upd.word_op ? (upd.result != 16'h0000) : (upd.result[7:0] != 8'h00);
    hc        = upd.word_op ? upd.half_carry_b8 : upd.half_carry_b4;
    nxt_flags = cur_flags;
    if (upd.valid) begin
      if (upd.affect[4]) nxt_flags[4] = hc;
      if (upd.affect[3]) nxt_flags[3] = neg;
      if (upd.affect[2]) nxt_flags[2] = upd.signed_ovf;
      // zero is sticky-clear only: a zero result keeps an earlier set state
      if (upd.affect[1] && nonzero) nxt_flags[1] = 1'b0;
      if (upd.affect[0]) nxt_flags[0] = upd.carry_out;
    end
  end
endmodule

// file: logic/asfr_prio_map.sv
`timescale 1ns/1ps
`include "asfr_defines.svh"

module asfr_prio_map (
  // priority field
  input  wire logic [2:0] prio,
  // derived views
  output logic [3:0]      ext_level,
  output logic            user_irq_block
);
  assign ext_level      = `ASFR_EXT_LEVEL_BASE + {1'b0, prio};
  assign user_irq_block = (prio == `ASFR_PRIO_BLOCK);
endmodule

// file: logic/asfr_status.sv
// Summary of operation
// - bits 15..9 have no storage and always read zero
// - half carry at bit 8: carry from bit 4 (byte) or bit 8 (word)
// - priority level is a 3-bit field in bits 7..5, levels 0..7
// - priority 7 blocks all user interrupt requests
// - extended interrupt level reported as priority plus eight
// - loop bit read-only; all bits zero after reset; others writable
// - loop bit at bit 4 high while a repeat loop runs
// - negative flag at bit 3 follows the result sign
// - overflow flag set on signed overflow, else cleared
// - zero flag cleared by a non-zero result of an affecting operation
`timescale 1ns/1ps
`include "asfr_defines.svh"

module asfr_status
  import asfr_pkg::*;
(
  // apb
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // execution logic
  input  wire asfr_upd_type upd,
  input  wire logic         repeat_active,
  // status outputs
  output logic [15:0]       status_word,
  output logic [3:0]        ext_level,
  output logic              user_irq_block
);
  // =====================================================
  // state
  logic [4:0]  flags_ff;
  logic [4:0]  nxt_flags;
  logic [4:0]  calc_flags;
  logic [2:0]  prio_ff;
  logic [2:0]  nxt_prio;
  logic        loop_ff;
  logic        nxt_loop;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        slverr_ff;
  logic        nxt_slverr;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit_status;
  logic        hit_exec;
  logic [15:0] word_view;

  asfr_flag_calc u_calc (
    .upd       (upd),
    .cur_flags (flags_ff),
    .nxt_flags (calc_flags)
  );

  asfr_prio_map u_prio (
    .prio           (prio_ff),
    .ext_level      (ext_level),
    .user_irq_block (user_irq_block)
  );

  // =====================================================
  // apb decode
  // zero-wait slave: the register bank is flops only, so no stall is needed
  assign pready     = 1'b1;
  assign hit_status = (paddr == `ASFR_STATUS_OFS);
  assign hit_exec   = (paddr == `ASFR_EXEC_OFS);
  assign wr_acc     = psel && penable && pwrite;
  assign rd_acc     = psel && penable && !pwrite;

  always_comb begin
    word_view = 16'h0000;
    word_view[`ASFR_HALF_CARRY_BIT]        = flags_ff[4];
    word_view[`ASFR_PRIO_HI:`ASFR_PRIO_LO] = prio_ff;
    word_view[`ASFR_LOOP_BIT]              = loop_ff;
    word_view[`ASFR_NEG_BIT]               = flags_ff[3];
    word_view[`ASFR_WRAP_BIT]              = flags_ff[2];
    word_view[`ASFR_ZERO_BIT]              = flags_ff[1];
    word_view[`ASFR_CARRY_BIT]             = flags_ff[0];
  end

  assign status_word = word_view & `ASFR_IMPL_MASK;

  // =====================================================
  // status next state
  // software write wins over a same-cycle execution update: a move into the
  // status word is itself the instruction that defines its final value
  always_comb begin
    nxt_flags = calc_flags;
    nxt_prio  = prio_ff;
    nxt_loop  = repeat_active;
    if (wr_acc && hit_status) begin
      if (pstrb[1]) nxt_flags[4] = pwdata[`ASFR_HALF_CARRY_BIT];
      if (pstrb[0]) begin
        nxt_prio     = pwdata[`ASFR_PRIO_HI:`ASFR_PRIO_LO];
        nxt_flags[3] = pwdata[`ASFR_NEG_BIT];
        nxt_flags[2] = pwdata[`ASFR_WRAP_BIT];
        nxt_flags[1] = pwdata[`ASFR_ZERO_BIT];
        nxt_flags[0] = pwdata[`ASFR_CARRY_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= 5'h00;
      prio_ff  <= 3'h0;
      loop_ff  <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      prio_ff  <= nxt_prio;
      loop_ff  <= nxt_loop;
    end
  end

  // =====================================================
  // read data
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_slverr = 1'b0;
    if (psel && !penable) begin
      nxt_prdata = 32'h0000_0000;
      if (!pwrite && hit_status) begin
        nxt_prdata = {16'h0000, status_word};
      end else if (!pwrite && hit_exec) begin
        nxt_prdata = {27'h000_0000, user_irq_block, ext_level};
      end
      nxt_slverr = !(hit_status || (hit_exec && !pwrite));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      slverr_ff <= nxt_slverr;
    end
  end

  assign prdata  = rd_acc ? prdata_ff : 32'h0000_0000;
  assign pslverr = psel && penable && slverr_ff;

  // =====================================================
  // checks
  property p_upper_zero;
    @(posedge pclk) disable iff (!presetn)
      status_word[15:9] == 7'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper status bits not zero");

  property p_half_carry;
    @(posedge pclk) disable iff (!presetn)
      (upd.valid && upd.affect[4] && !(wr_acc && hit_status))
      |=> status_word[8] == $past(upd.word_op ? upd.half_carry_b8 : upd.half_carry_b4);
  endproperty
  a_half_carry: assert property (p_half_carry) else $error("half carry wrong");

  property p_prio_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_status && pstrb[0]) |=> status_word[7:5] == $past(pwdata[7:5]);
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority not written");

  property p_block;
    @(posedge pclk) disable iff (!presetn)
      user_irq_block == (status_word[7:5] == 3'h7);
  endproperty
  a_block: assert property (p_block) else $error("user block mismatch");

  property p_ext_level;
    @(posedge pclk) disable iff (!presetn)
      ext_level == {1'b1, status_word[7:5]};
  endproperty
  a_ext_level: assert property (p_ext_level) else $error("extended level wrong");

  property p_loop_ro;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> status_word[4] == $past(repeat_active);
  endproperty
  a_loop_ro: assert property (p_loop_ro) else $error("loop bit not following repeat");

  property p_neg;
    @(posedge pclk) disable iff (!presetn)
      (upd.valid && upd.affect[3] && !(wr_acc && hit_status))
      |=> status_word[3] == $past(upd.word_op ? upd.result[15] : upd.result[7]);
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (upd.valid && upd.affect[2] && !(wr_acc && hit_status)) |=> status_word[2] == $past(upd.signed_ovf);
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow flag wrong");

  property p_zero;
    @(posedge pclk) disable iff (!presetn)
      (upd.valid && upd.affect[1] && upd.word_op && upd.result != 16'h0000 && !(wr_acc && hit_status))
      |=> !status_word[1];
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag not cleared");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (!upd.valid && !(wr_acc && hit_status)) |=> $stable(status_word[8:5]) && $stable(status_word[3:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed without cause");

  // no disable here: the check is about what reset itself leaves behind
  property p_reset_clear;
    @(posedge pclk)
      $rose(presetn) |-> status_word == 16'h0000 && ext_level == 4'h8 && !user_irq_block;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset values wrong");

  property p_loop_no_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_status) |=> status_word[4] == $past(repeat_active);
  endproperty
  a_loop_no_write: assert property (p_loop_no_write) else $error("loop bit taken from software");

  property p_refused;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !(hit_status || (hit_exec && !pwrite))) |-> pslverr;
  endproperty
  a_refused: assert property (p_refused) else $error("refused access not flagged");

  property p_read_status;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_status) |=> prdata == {16'h0000, $past(status_word)};
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read data wrong");

  property p_read_view;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_exec)
      |=> prdata == {27'h000_0000, $past(user_irq_block), $past(ext_level)};
  endproperty
  a_read_view: assert property (p_read_view) else $error("level view read wrong");

  property p_hc_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_status && pstrb[1]) |=> status_word[8] == $past(pwdata[8]);
  endproperty
  a_hc_write: assert property (p_hc_write) else $error("half carry not written");

  property p_flags_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_status && pstrb[0]) |=> status_word[3:0] == $past(pwdata[3:0]);
  endproperty
  a_flags_write: assert property (p_flags_write) else $error("low flags not written");

  property p_hc_byte;
    @(posedge pclk) disable iff (!presetn)
      (upd.valid && upd.affect[4] && !upd.word_op && !(wr_acc && hit_status))
      |=> status_word[8] == $past(upd.half_carry_b4);
  endproperty
  a_hc_byte: assert property (p_hc_byte) else $error("byte half carry wrong");

  property p_neg_byte;
    @(posedge pclk) disable iff (!presetn)
      (upd.valid && upd.affect[3] && !upd.word_op && !(wr_acc && hit_status)) |=> status_word[3] == $past(upd.result[7]);
  endproperty
  a_neg_byte: assert property (p_neg_byte) else $error("byte negative flag wrong");

  property p_zero_byte;
    @(posedge pclk) disable iff (!presetn)
      (upd.valid && upd.affect[1] && !upd.word_op && upd.result[7:0] != 8'h00 && !(wr_acc && hit_status))
      |=> !status_word[1];
  endproperty
  a_zero_byte: assert property (p_zero_byte) else $error("byte zero flag not cleared");

  // hardware only ever clears zero; a set state comes from software alone
  property p_zero_no_set;
    @(posedge pclk) disable iff (!presetn)
      (!status_word[1] && !(wr_acc && hit_status)) |=> !status_word[1];
  endproperty
  a_zero_no_set: assert property (p_zero_no_set) else $error("zero flag set by hardware");

  property p_prio_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr_acc && hit_status && pstrb[0]) |=> $stable(status_word[7:5]);
  endproperty
  a_prio_hold: assert property (p_prio_hold) else $error("priority changed without write");

  for (genvar g = 0; g < 5; g++) begin : g_keep
    property p_keep;
      @(posedge pclk) disable iff (!presetn)
        (upd.valid && !upd.affect[g] && !(wr_acc && hit_status)) |=> flags_ff[g] == $past(flags_ff[g]);
    endproperty
    a_keep: assert property (p_keep) else $error("unaffected flag changed");
  end

  // =====================================================
  // coverage

  c_write: cover property (@(posedge pclk) disable iff (!presetn) wr_acc && hit_status);
  c_block: cover property (@(posedge pclk) disable iff (!presetn) user_irq_block);
  c_loop:  cover property (@(posedge pclk) disable iff (!presetn) status_word[4] ##1 !status_word[4]);
  c_wrap:  cover property (@(posedge pclk) disable iff (!presetn) upd.valid && upd.affect[2] && upd.signed_ovf);
  c_error: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// file: testbench/asfr_exec_model.sv
`timescale 1ns/1ps

// =====================================================
// execution logic stand-in: adds two operands
module asfr_exec_model
  import asfr_pkg::*;
(
  // operation request
  input  wire logic        go,
  input  wire logic        word_op,
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  input  wire logic [4:0]  affect,
  input  wire logic        rep,
  // toward the status block
  output asfr_upd_type     upd,
  output logic             repeat_active
);
  logic [16:0] sum;
  logic [4:0]  low4;
  logic [8:0]  low8;

  always_comb begin
    sum = word_op ? {1'b0, a} + {1'b0, b} : {9'h000, a[7:0]} + {9'h000, b[7:0]};
    low4 = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    low8 = {1'b0, a[7:0]} + {1'b0, b[7:0]};
    upd.valid = go;
    upd.word_op = word_op;
    upd.result = word_op ? sum[15:0] : {8'h00, sum[7:0]};
    upd.carry_out = word_op ? sum[16] : sum[8];
    upd.half_carry_b4 = low4[4];
    upd.half_carry_b8 = low8[8];
    // sign of both operands equal but sign of sum differs
    upd.signed_ovf = word_op ? (a[15] == b[15]) && (sum[15] != a[15]) : (a[7] == b[7]) && (sum[7] != a[7]);
    upd.affect = affect;
    repeat_active = rep;
  end
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps

`define CHK(n, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); \
  end \
end

module tb;
  import asfr_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, wd;
  logic [3:0]   pstrb, ext_level;
  logic         go, word_op, rep, repeat_active, user_irq_block;
  logic [15:0]  a, b, status_word, exp_sw;
  logic [4:0]   affect;
  asfr_upd_type upd;
  int           num_errors, total_checks;

  asfr_exec_model i_model (.go(go), .word_op(word_op), .a(a), .b(b), .affect(affect), .rep(rep),
    .upd(upd), .repeat_active(repeat_active));
  asfr_status i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .upd(upd), .repeat_active(repeat_active), .status_word(status_word), .ext_level(ext_level),
    .user_irq_block(user_irq_block));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // =====================================================
  // helpers
  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one apb transfer plus one idle cycle, so callers resume right after an edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] ro,
                     output logic eo);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      summarize();
    end
    ro = prdata;
    eo = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [15:0] nxt_exp(logic [15:0] sw, asfr_upd_type u);
    logic [15:0] r;
    r = sw;
    if (u.affect[4]) r[8] = u.word_op ? u.half_carry_b8 : u.half_carry_b4;
    if (u.affect[3]) r[3] = u.word_op ? u.result[15] : u.result[7];
    if (u.affect[2]) r[2] = u.signed_ovf;
    if (u.affect[1] && (u.word_op ? u.result != 16'h0000 : u.result[7:0] != 8'h00)) r[1] = 1'b0;
    if (u.affect[0]) r[0] = u.carry_out;
    return r;
  endfunction

  // =====================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, word_op, rep} = 6'h00;
    {paddr, pwdata, a, b, affect} = '0;
    pstrb = 4'hf;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(30));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    `CHK("reset", 32'h0, rd)
    apb(1'b1, 12'h000, 32'hffffffff, rd, err);
    `CHK("mask", 16'h01ef, status_word)
    for (int p = 0; p < 8; p++) begin
      apb(1'b1, 12'h000, 32'(p << 5), rd, err);
      `CHK("lvl", 4'(p + 8), ext_level)
      `CHK("blk", logic'(p == 7), user_irq_block)
      apb(1'b0, 12'h004, 32'h0, rd, err);
      `CHK("view", {27'h0, logic'(p == 7), 4'(p + 8)}, rd)
    end
    // refused accesses must leave the word alone
    apb(1'b1, 12'h004, 32'h0, rd, err);
    `CHK("ro_err", 1'b1, err)
    apb(1'b0, 12'h010, 32'h0, rd, err);
    `CHK("map_err", 1'b1, err)
    `CHK("kept", 16'h00e0, status_word)
    exp_sw = 16'h00e0;
    for (int i = 0; i < 40; i++) begin
      if (i % 8 == 0) begin
        wd = (i == 0) ? 32'h2 : $urandom;
        apb(1'b1, 12'h000, wd, rd, err);
        exp_sw = (wd[15:0] & 16'h01ef) | {11'h0, rep, 4'h0};
      end
      go <= 1'b1;
      word_op <= (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
      a <= (i == 0) ? 16'h7fff : (i == 1) ? 16'h00ff : 16'($urandom);
      b <= (i < 2) ? 16'h0001 : 16'($urandom);
      affect <= (i < 2) ? 5'h1f : 5'($urandom);
      rep <= 1'($urandom);
      @(posedge pclk);
      exp_sw = nxt_exp(exp_sw, upd);
      exp_sw[4] = rep;
      go <= 1'b0;
      @(posedge pclk);
      `CHK("flags", exp_sw, status_word)
    end
    apb(1'b0, 12'h000, 32'h0, rd, err);
    `CHK("readback", {16'h0000, exp_sw}, rd)
    // byte lanes: lane 1 carries only the half carry, lane 0 the rest
    pstrb <= 4'h2;
    apb(1'b1, 12'h000, 32'h0, rd, err);
    exp_sw[8] = 1'b0;
    `CHK("strb_hi", exp_sw, status_word)
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'h1ff, rd, err);
    exp_sw[7:0] = {3'h7, rep, 4'hf};
    `CHK("strb_lo", exp_sw, status_word)
    pstrb <= 4'hf;
    // second reset in mid-run
    rep <= 1'b0;
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK("rst_mid", 16'h0000, status_word)
    `CHK("rst_lvl", 4'h8, ext_level)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    `CHK("rst_rd", 32'h0, rd)
    summarize();
  end
endmodule
